// File: clock_config_pkg.sv
// shared constants and carrier types for the clock configuration block
package clock_config_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] CFG_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;
    // field positions in the configuration register
    localparam int CLKOUT_DIV_LSB = 28;
    localparam int PLL_MUL_HI_BIT = 27;
    localparam int CLKOUT_SRC_LSB = 24;
    localparam int USB_DIV_LSB = 22;
    localparam int PLL_MUL_LO_LSB = 18;
    localparam int PLL_PREDIV_BIT = 17;
    localparam int PLL_REF_BIT = 16;
    localparam int BUS_DIV_LSB = 11;
    // field position in the control register
    localparam int PLL_EN_BIT = 24;
    // field positions in the status register
    localparam int STAT_MUL_LSB = 0;
    localparam int STAT_BUS_LSB = 8;
    // reset values and masks
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic CTRL_PLL_EN_RESET = 1'b0;
    localparam logic [31:0] CFG_WRITE_MASK = 32'hffff_3800;
    localparam logic [31:0] CFG_LOCK_MASK = 32'h083f_0000;
    // response codes
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // number of selectable clock-output sources
    localparam int NUM_SOURCES = 7;
    localparam int PLL_SOURCE_IDX = 6;
    // divider shape: counts are in half periods of the source
    localparam int SHAPE_W = 6;
    typedef struct packed {
        logic [SHAPE_W-1:0] period;
        logic [SHAPE_W-1:0] high;
    } div_shape_t;
    // unpacked view of the configuration register
    typedef struct packed {
        logic [3:0] clkout_divider;
        logic [2:0] clkout_source_select;
        logic [1:0] usb_clock_divider;
        logic [4:0] pll_multiplier;
        logic pll_ext_predivide;
        logic pll_reference_select;
        logic [2:0] fast_periph_bus_divider;
    } clk_cfg_t;
endpackage

// File: clk_sync.sv
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module clk_sync #(
    parameter int WIDTH = 7
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // first stage feeds only the second stage
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule
`default_nettype wire

// File: half_period_divider.sv
// divides a sampled clock level by counting its half periods
`timescale 1ns/1ps
`default_nettype none
module half_period_divider
    import clock_config_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic src_level,
    input wire logic restart,
    input wire clock_config_pkg::div_shape_t shape,
    output logic out_clk
);
    import clock_config_pkg::*;
    logic prev_reg;
    logic prev_next;
    logic armed_reg;
    logic armed_next;
    logic [SHAPE_W-1:0] count_reg;
    logic [SHAPE_W-1:0] count_next;
    logic out_reg;
    logic out_next;
    logic edge_seen;
    logic rise_seen;

    // a restart drops the output and waits for a clean rising edge
    always_comb begin
        edge_seen = src_level != prev_reg;
        rise_seen = src_level & ~prev_reg;
        prev_next = src_level;
        armed_next = armed_reg;
        count_next = count_reg;
        out_next = out_reg;
        if (restart) begin
            armed_next = 1'b0;
            count_next = '0;
            out_next = 1'b0;
        end else if (!armed_reg) begin
            if (rise_seen) begin
                armed_next = 1'b1;
                count_next = '0;
                out_next = 1'b1;
            end
        end else if (edge_seen) begin
            // high for the first 'high' half periods of each 'period'
            if (count_reg + 1'b1 >= shape.period) begin
                count_next = '0;
            end else begin
                count_next = count_reg + 1'b1;
            end
            out_next = count_next < shape.high;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_reg <= 1'b0;
            armed_reg <= 1'b0;
            count_reg <= '0;
            out_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            armed_reg <= armed_next;
            count_reg <= count_next;
            out_reg <= out_next;
        end
    end

    assign out_clk = out_reg;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_restart_low: assert property (
        restart |=> !out_reg && !armed_reg)
        else $error("divider output not dropped after restart");
    a_phase_count: assert property (
        armed_reg && !restart && $past(armed_reg) |-> out_reg == (count_reg < shape.high))
        else $error("divider output does not match its phase count");
endmodule
`default_nettype wire

// File: clock_config_dividers.sv
// clock configuration register with clock-output and usb clock dividers
`timescale 1ns/1ps
`default_nettype none
// Operation
// - clock-output divider code 0 passes the source with its own duty cycle.
// - codes 1 to 7 divide by code plus one, high for one source half period.
// - codes 8 to 15 divide by 2,4..16 with fifty percent duty cycle.
// - source select 1..7 picks one of seven clocks; zero gives no output.
// - clock output may be truncated when starting or switching source.
// - usb divider codes 0..3 divide the pll output by 1.5, 1, 2, 3.
// - pll multiplier is five bits: bit 27 on top of bits 21:18.
// - multiplier codes 0..14 give code plus two, 15 gives 16, above code plus one.
// - bit 17 halves the external oscillator before the pll; locked while pll runs.
// - bit 16 picks the pll reference; locked while the pll runs.
// - bus divider: leading zero undivided, 100..111 divide by 2, 4, 8, 16.
// - pll enable is software set and cleared, cleared on deep stop entry.
module clock_config_dividers
    import clock_config_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [clock_config_pkg::NUM_SOURCES-1:0] clkout_sources,
    input wire logic deep_stop_entry,
    output logic clkout_pin,
    output logic usb_clock,
    output logic pll_enable,
    output logic [5:0] pll_multiplier_factor,
    output logic pll_reference_select,
    output logic pll_ext_predivide,
    output logic [4:0] fast_periph_bus_factor
);
    import clock_config_pkg::*;

    if (ADDR_W < 5) begin : g_addr_check
        $error("ADDR_W too small to reach the status register");
    end

    // bus slave state
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
    logic [ADDR_W-1:0] waddr_reg, waddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next, rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    // register state
    logic [31:0] cfg_reg, cfg_next;
    logic pll_en_reg, pll_en_next;
    logic [5:0] mul_reg, mul_next;
    logic [4:0] bus_reg, bus_next;
    logic [6:0] clkout_sel_reg, clkout_sel_next;
    logic [1:0] usb_sel_reg, usb_sel_next;
    // combinational helpers
    logic do_write;
    logic [31:0] byte_mask, cfg_mask;
    clk_cfg_t cfg;
    logic [NUM_SOURCES-1:0] src_sync;
    logic clkout_level;
    div_shape_t clkout_shape, usb_shape;
    logic [4:0] fact_m1;

    // field view of the configuration register
    assign cfg.clkout_divider = cfg_reg[CLKOUT_DIV_LSB +: 4];
    assign cfg.clkout_source_select = cfg_reg[CLKOUT_SRC_LSB +: 3];
    assign cfg.usb_clock_divider = cfg_reg[USB_DIV_LSB +: 2];
    assign cfg.pll_multiplier = {cfg_reg[PLL_MUL_HI_BIT], cfg_reg[PLL_MUL_LO_LSB +: 4]};
    assign cfg.pll_ext_predivide = cfg_reg[PLL_PREDIV_BIT];
    assign cfg.pll_reference_select = cfg_reg[PLL_REF_BIT];
    assign cfg.fast_periph_bus_divider = cfg_reg[BUS_DIV_LSB +: 3];

    // write channel: address and data taken in either order, answered once both held
    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next = w_held_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        do_write = aw_held_reg && w_held_reg && !bvalid_reg;
        if (s_axi_awvalid && awready_reg) begin
            aw_held_next = 1'b1;
            waddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_held_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            if (waddr_reg == ADDR_W'(CTRL_OFFSET) || waddr_reg == ADDR_W'(CFG_OFFSET)
                    || waddr_reg == ADDR_W'(STATUS_OFFSET)) begin
                bresp_next = RESP_OKAY;
            end else begin
                bresp_next = RESP_SLVERR;
            end
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        // no new beat until the response has gone
        awready_next = !aw_held_next && !bvalid_next;
        wready_next = !w_held_next && !bvalid_next;
    end

    // byte lanes of the pending write
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            byte_mask[8*i +: 8] = {8{wstrb_reg[i]}};
        end
        // pll fields are frozen while the pll runs, so retuning needs a stop first
        cfg_mask = byte_mask & CFG_WRITE_MASK;
        if (pll_en_reg) begin
            cfg_mask = cfg_mask & ~CFG_LOCK_MASK;
        end
    end

    // configuration and control registers
    always_comb begin
        cfg_next = cfg_reg;
        pll_en_next = pll_en_reg;
        if (do_write && waddr_reg == ADDR_W'(CFG_OFFSET)) begin
            cfg_next = (cfg_reg & ~cfg_mask) | (wdata_reg & cfg_mask);
        end
        if (do_write && waddr_reg == ADDR_W'(CTRL_OFFSET) && wstrb_reg[PLL_EN_BIT/8]) begin
            pll_en_next = wdata_reg[PLL_EN_BIT];
        end
        // stop entry wins over a software set in the same cycle
        if (deep_stop_entry) begin
            pll_en_next = 1'b0;
        end
    end

    // read channel: one beat in flight, data one cycle after address
    always_comb begin
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid && arready_reg) begin
            arready_next = 1'b0;
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = '0;
            if (s_axi_araddr == ADDR_W'(CTRL_OFFSET)) begin
                rdata_next[PLL_EN_BIT] = pll_en_reg;
            end else if (s_axi_araddr == ADDR_W'(CFG_OFFSET)) begin
                rdata_next = cfg_reg; // reserved bits never stored, read zero
            end else if (s_axi_araddr == ADDR_W'(STATUS_OFFSET)) begin
                rdata_next[STAT_MUL_LSB +: 6] = mul_reg;
                rdata_next[STAT_BUS_LSB +: 5] = bus_reg;
            end else begin
                rresp_next = RESP_SLVERR;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
            arready_next = 1'b1;
        end
        // after reset nothing is in flight, so open the address channel
        if (!arready_reg && !rvalid_reg) begin
            arready_next = 1'b1;
        end
    end

    // decoded factors and change detection for the dividers
    always_comb begin
        if (cfg.pll_multiplier < 5'h0f) begin
            mul_next = {1'b0, cfg.pll_multiplier} + 6'h02;
        end else if (cfg.pll_multiplier == 5'h0f) begin
            mul_next = 6'h10;
        end else begin
            mul_next = {1'b0, cfg.pll_multiplier} + 6'h01;
        end
        if (!cfg.fast_periph_bus_divider[2]) begin
            bus_next = 5'h01;
        end else begin
            bus_next = 5'h02 << cfg.fast_periph_bus_divider[1:0];
        end
        clkout_sel_next = {cfg.clkout_divider, cfg.clkout_source_select};
        usb_sel_next = cfg.usb_clock_divider;
    end

    // clock-output shape; counts are in source half periods
    always_comb begin
        fact_m1 = {1'b0, cfg.clkout_divider};
        if (!cfg.clkout_divider[3]) begin
            // code 0 gives period 2, high 1: the source itself
            clkout_shape.period = SHAPE_W'({fact_m1, 1'b0}) + 6'h02;
            clkout_shape.high = 6'h01;
        end else begin
            clkout_shape.high = SHAPE_W'({fact_m1 - 5'h07, 1'b0});
            clkout_shape.period = SHAPE_W'({fact_m1 - 5'h07, 2'b00});
        end
        // 1.5 needs both pll edges: three half periods, high for two
        case (cfg.usb_clock_divider)
            2'b00: usb_shape = '{period: 6'h03, high: 6'h02};
            2'b01: usb_shape = '{period: 6'h02, high: 6'h01};
            2'b10: usb_shape = '{period: 6'h04, high: 6'h02};
            default: usb_shape = '{period: 6'h06, high: 6'h03};
        endcase
    end

    // source clocks arrive asynchronously; aclk must run well above the chosen source
    clk_sync #(
        .WIDTH(NUM_SOURCES)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(clkout_sources),
        .sync_out(src_sync)
    );

    // code zero selects nothing and leaves the output low
    assign clkout_level = (cfg.clkout_source_select != 3'h0)
        ? src_sync[cfg.clkout_source_select - 3'h1] : 1'b0;

    // a change of setting cuts the current pulse short
    half_period_divider u_clkout_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .src_level(clkout_level),
        .restart(clkout_sel_next != clkout_sel_reg),
        .shape(clkout_shape),
        .out_clk(clkout_pin)
    );

    half_period_divider u_usb_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .src_level(src_sync[PLL_SOURCE_IDX]),
        .restart(usb_sel_next != usb_sel_reg),
        .shape(usb_shape),
        .out_clk(usb_clock)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
            cfg_reg <= CFG_RESET;
            pll_en_reg <= CTRL_PLL_EN_RESET;
            mul_reg <= 6'h02;
            bus_reg <= 5'h01;
            clkout_sel_reg <= '0;
            usb_sel_reg <= '0;
        end else begin
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            cfg_reg <= cfg_next;
            pll_en_reg <= pll_en_next;
            mul_reg <= mul_next;
            bus_reg <= bus_next;
            clkout_sel_reg <= clkout_sel_next;
            usb_sel_reg <= usb_sel_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign pll_enable = pll_en_reg;
    assign pll_multiplier_factor = mul_reg;
    assign fast_periph_bus_factor = bus_reg;
    assign pll_reference_select = cfg_reg[PLL_REF_BIT];
    assign pll_ext_predivide = cfg_reg[PLL_PREDIV_BIT];

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_mul_lock: assert property (
        $past(pll_en_reg) |-> $stable(cfg.pll_multiplier))
        else $error("multiplier changed while pll enabled");
    a_ref_lock: assert property (
        $past(pll_en_reg) |-> $stable(cfg_reg[PLL_PREDIV_BIT:PLL_REF_BIT]))
        else $error("pll reference or predivide changed while pll enabled");
    a_mul_decode: assert property (
        $stable(cfg.pll_multiplier) |-> mul_reg == ((cfg.pll_multiplier < 5'h0f)
            ? 6'(cfg.pll_multiplier) + 6'h02 : (cfg.pll_multiplier == 5'h0f)
            ? 6'h10 : 6'(cfg.pll_multiplier) + 6'h01))
        else $error("pll multiplier factor wrong");
    a_stop_clear: assert property (
        deep_stop_entry |=> !pll_enable ##1 (pll_enable == $past(pll_en_next)))
        else $error("pll enable not cleared by stop entry");
    a_bus_div: assert property (
        $stable(cfg.fast_periph_bus_divider) |-> bus_reg == (cfg.fast_periph_bus_divider[2]
            ? (5'h02 << cfg.fast_periph_bus_divider[1:0]) : 5'h01))
        else $error("bus divider factor wrong");
    a_src_none: assert property (
        (cfg.clkout_source_select == 3'h0) [*3] |-> !clkout_pin)
        else $error("clock output active with no source");
    a_shape_sel: assert property (
        clkout_shape.period == 6'(2 * ((cfg.clkout_divider[3])
            ? 2 * (cfg.clkout_divider - 4'h7) : cfg.clkout_divider + 4'h1))
        && clkout_shape.high == (cfg.clkout_divider[3] ? clkout_shape.period >> 1 : 6'h01))
        else $error("clock output shape wrong");
    a_write_resp: assert property (
        do_write |=> s_axi_bvalid)
        else $error("write response missing");

    c_locked_write: cover property (do_write && pll_en_reg && waddr_reg == ADDR_W'(CFG_OFFSET));
    c_usb_frac: cover property (cfg.usb_clock_divider == 2'b00 && $rose(usb_clock));
    c_clkout_even: cover property (cfg.clkout_divider[3] && $rose(clkout_pin));
    c_stop_entry: cover property (deep_stop_entry && pll_en_reg);
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the clock configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import clock_config_pkg::*;
    typedef struct {
        logic [31:0] d;
        int mul, bus, chi, cper, uhi, uper;
    } row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [6:0] srcs = 7'h00;
    logic [6:0] live = 7'h7f;
    logic stop = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pin, usb, pen, pref, ppre;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [5:0] mulf;
    logic [4:0] busf;
    int num_errors = 0, total_checks = 0, tick = 0;
    // data, multiplier, bus factor, clock-out high/period, usb high/period
    row_t rows [7] = '{
        '{32'h0140_0000, 2, 1, 8, 16, 8, 16},
        '{32'h12b8_3800, 16, 16, 8, 32, 16, 32},
        '{32'h73fc_2000, 16, 2, 8, 128, 24, 48},
        '{32'h8c00_2800, 17, 4, 16, 32, 16, 24},
        '{32'hff7c_3000, 32, 8, 128, 256, 8, 16},
        '{32'h0500_0000, 2, 1, 8, 16, 16, 24},
        '{32'h9647_1800, 3, 1, 32, 64, 8, 16}};

    always #25 aclk = ~aclk;
    // live sources toggle at one slow rate well below aclk/4; idle ones stay low,
    // so a wrong source select shows up as a missing clock
    always @(posedge aclk) begin
        tick <= tick + 1;
        if (tick % 8 == 7) srcs <= ~srcs & live;
    end

    clock_config_dividers dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .clkout_sources(srcs), .deep_stop_entry(stop),
        .clkout_pin(pin), .usb_clock(usb), .pll_enable(pen), .pll_multiplier_factor(mulf),
        .pll_reference_select(pref), .pll_ext_predivide(ppre), .fast_periph_bus_factor(busf)
    );

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task give_verdict;
        if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task hang;
        num_errors++;
        give_verdict();
    endtask

    // address and data offered together, each released once taken
    task wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 300; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 300) hang();
        chk("bresp", {30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task rchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 300; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 300) hang();
        chk(nm, rdata, e);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // skips the first, possibly truncated pulse, then times one whole period
    task meas(input bit sel, output int hi, output int per);
        int n, st;
        logic v, pv;
        st = 0;
        pv = 1'b0;
        for (n = 0; n < 3000 && st < 5; n++) begin
            @(posedge aclk);
            v = sel ? usb : pin;
            if (st == 4) begin
                if (v && !pv) st = 5;
                else begin
                    per++;
                    hi += v;
                end
            end else if (v === st[0]) begin
                st++;
                hi = 1;
                per = 1;
            end
            pv = v;
        end
        if (st != 5) hang();
    endtask

    initial begin
        int hi, per;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk("pin_rst", pin, 0);
        chk("pll_en_rst", pen, 0);
        chk("mul_rst", mulf, 2);
        chk("bus_rst", busf, 1);
        rchk("cfg_rst", CFG_OFFSET, CFG_RESET, RESP_OKAY);
        rchk("ctrl_rst", CTRL_OFFSET, 32'h0000_0000, RESP_OKAY);
        foreach (rows[i]) begin
            live <= 7'h40 | (7'h01 << (rows[i].d[26:24] - 3'h1));
            wchk(CFG_OFFSET, rows[i].d, RESP_OKAY);
            rchk("cfg", CFG_OFFSET, rows[i].d & CFG_WRITE_MASK, RESP_OKAY);
            rchk("status", STATUS_OFFSET,
                {19'h0, 5'(rows[i].bus), 2'h0, 6'(rows[i].mul)}, RESP_OKAY);
            chk("mul", mulf, rows[i].mul);
            chk("bus", busf, rows[i].bus);
            chk("ref", pref, rows[i].d[16]);
            chk("pre", ppre, rows[i].d[17]);
            meas(1'b0, hi, per);
            chk("clk_hi", hi, rows[i].chi);
            chk("clk_per", per, rows[i].cper);
            meas(1'b1, hi, per);
            chk("usb_hi", hi, rows[i].uhi);
            chk("usb_per", per, rows[i].uper);
        end
        // pll settings must hold while the pll runs, other fields still move
        wchk(CTRL_OFFSET, 32'h0100_0000, RESP_OKAY);
        chk("pll_en", pen, 1);
        wchk(CFG_OFFSET, 32'h0000_0000, RESP_OKAY);
        rchk("cfg_lock", CFG_OFFSET, rows[6].d & CFG_LOCK_MASK, RESP_OKAY);
        chk("mul_lock", mulf, 3);
        hi = 0;
        repeat (64) begin
            @(posedge aclk);
            hi += pin;
        end
        chk("pin_off", hi, 0);
        stop <= 1'b1;
        @(posedge aclk);
        stop <= 1'b0;
        @(posedge aclk);
        chk("pll_stop", pen, 0);
        rchk("ctrl_stop", CTRL_OFFSET, 32'h0000_0000, RESP_OKAY);
        wchk(CFG_OFFSET, 32'h0000_0000, RESP_OKAY);
        rchk("cfg_open", CFG_OFFSET, 32'h0000_0000, RESP_OKAY);
        wchk(8'h08, 32'hffff_ffff, RESP_SLVERR);
        rchk("unmapped", 8'h08, 32'h0000_0000, RESP_SLVERR);
        wchk(STATUS_OFFSET, 32'hffff_ffff, RESP_OKAY);
        rchk("status_ro", STATUS_OFFSET, 32'h0000_0102, RESP_OKAY);
        // a reset in mid-run must return every setting to its reset value
        wchk(CFG_OFFSET, rows[4].d, RESP_OKAY);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk("mul_rst2", mulf, 2);
        chk("pin_rst2", pin, 0);
        rchk("cfg_rst2", CFG_OFFSET, CFG_RESET, RESP_OKAY);
        give_verdict();
    end
endmodule
`default_nettype wire
